//--- hw/mbs_device.sv
// Device end: bus cycle state, encoded status, request/grant handshake.
// Assumes pins resolved outside; handoff pins and ready are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module mbs_device
    import mbs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic nrst,
    mbs_link_if.device link,
    input wire logic bus_style_select,
    input wire logic cyc_req,
    input wire logic [2:0] cyc_kind,
    input wire logic cyc_odd_low,
    input wire logic cyc_first_interrupt_ack_cycle,
    input wire logic lock_active,
    output logic cyc_done_ff,
    output logic granted_ff
);
    logic [1:0] hi_sync_ff;
    logic [1:0] lo_sync_ff;
    logic [1:0] rdy_sync_ff;
    logic [1:0] style_sync_ff;
    logic [3:0] gnt_dly_ff;
    logic hi_prev_ff;
    logic lo_prev_ff;
    logic hi_fall;
    logic lo_fall;
    mbs_bus_t bus_ff, nxt_bus;
    mbs_hs_t hs_ff, nxt_hs;
    logic [2:0] kind_ff, nxt_kind;
    logic [2:0] st_o_ff, nxt_st_o;
    logic [2:0] st_oe_ff, nxt_st_oe;
    logic gnt_pin_ff, nxt_gnt_pin;
    logic gnt_lo_ff, nxt_gnt_lo;
    logic sel_lo_ff, nxt_sel_lo;
    logic early_ff, nxt_early;
    logic block_ff, nxt_block;
    logic lo_pend_ff, nxt_lo_pend;
    logic done_nxt;
    logic gnt_nxt;
    logic max_mode;
    logic sel_fall;
    logic can_release;

    // Two-stage synchronisers for pins and ready
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hi_sync_ff <= 2'h3;
            lo_sync_ff <= 2'h3;
            rdy_sync_ff <= 2'h0;
            style_sync_ff <= 2'h3;
            gnt_dly_ff <= 4'h0;
            hi_prev_ff <= 1'b1;
            lo_prev_ff <= 1'b1;
        end else begin
            hi_sync_ff <= {hi_sync_ff[0], link.bus_handoff_pin_high_prio};
            lo_sync_ff <= {lo_sync_ff[0], link.bus_handoff_pin_low_prio};
            rdy_sync_ff <= {rdy_sync_ff[0], link.ready};
            style_sync_ff <= {style_sync_ff[0], bus_style_select};
            gnt_dly_ff <= {gnt_dly_ff[1:0], gnt_lo_ff, gnt_pin_ff};
            hi_prev_ff <= hi_sync_ff[1];
            lo_prev_ff <= lo_sync_ff[1];
        end
    end

    // Ignore our own grant pulse coming back on the pin
    assign hi_fall = hi_prev_ff && !hi_sync_ff[1] && !gnt_dly_ff[2];
    assign lo_fall = lo_prev_ff && !lo_sync_ff[1] && !gnt_dly_ff[3];
    assign max_mode = (style_sync_ff[1] == MBS_STYLE_MAX);
    assign sel_fall = sel_lo_ff ? lo_fall : hi_fall;
    assign can_release = early_ff && !block_ff;

    always_comb begin
        nxt_bus = bus_ff;
        nxt_kind = kind_ff;
        nxt_hs = hs_ff;
        nxt_sel_lo = sel_lo_ff;
        nxt_gnt_pin = 1'b0;
        nxt_gnt_lo = 1'b0;
        nxt_lo_pend = lo_pend_ff;
        nxt_early = early_ff;
        nxt_block = block_ff;
        done_nxt = 1'b0;
        gnt_nxt = granted_ff;
        // Handshake: request, grant, release, then one idle clock
        case (hs_ff)
            MBS_HS_IDLE: begin
                if (max_mode && hi_fall) begin
                    nxt_hs = MBS_HS_PEND;
                    nxt_sel_lo = 1'b0;
                    nxt_lo_pend = lo_pend_ff || lo_fall;
                end else if (max_mode && (lo_fall || lo_pend_ff)) begin
                    nxt_hs = MBS_HS_PEND;
                    nxt_sel_lo = 1'b1;
                    nxt_lo_pend = 1'b0;
                end
                // Request on or before second state counts as early
                nxt_early = (bus_ff != MBS_T3) && (bus_ff != MBS_TW)
                    && (bus_ff != MBS_T4);
            end
            MBS_HS_GRANTED: begin
                if (sel_fall) begin
                    nxt_hs = MBS_HS_GAP;
                    nxt_bus = MBS_T4;
                    gnt_nxt = 1'b0;
                end
            end
            MBS_HS_GAP: nxt_hs = MBS_HS_IDLE;
            default: nxt_hs = hs_ff;
        endcase
        // Bus cycle sequencing
        case (bus_ff)
            MBS_TI, MBS_T4: begin
                done_nxt = (bus_ff == MBS_T4);
                if (hs_ff == MBS_HS_PEND
                    && (bus_ff == MBS_TI || can_release)) begin
                    nxt_gnt_pin = !sel_lo_ff;
                    nxt_gnt_lo = sel_lo_ff;
                    nxt_hs = MBS_HS_GRANTED;
                    nxt_bus = MBS_TG;
                    gnt_nxt = 1'b1;
                end else if (cyc_req && max_mode) begin
                    nxt_bus = MBS_T1;
                    nxt_kind = cyc_kind;
                    nxt_block = cyc_odd_low || cyc_first_interrupt_ack_cycle || lock_active;
                    nxt_early = 1'b1;
                end else begin
                    nxt_bus = MBS_TI;
                end
            end
            MBS_T1: nxt_bus = MBS_T2;
            MBS_T2: nxt_bus = rdy_sync_ff[1] ? MBS_T3 : MBS_TW;
            MBS_T3: nxt_bus = MBS_T4;
            MBS_TW: nxt_bus = rdy_sync_ff[1] ? MBS_T3 : MBS_TW;
            MBS_TG: begin
            end
            default: nxt_bus = MBS_TI;
        endcase
        // Status drive follows the next bus state
        nxt_st_oe = 3'h7;
        nxt_st_o = MBS_ST_PASSIVE;
        case (nxt_bus)
            MBS_T1, MBS_T2: nxt_st_o = kind_ff;
            MBS_T4: begin
                if (cyc_req && max_mode
                    && !(hs_ff == MBS_HS_PEND && can_release)) begin
                    nxt_st_o = cyc_kind;
                end
            end
            MBS_T3: nxt_st_o = MBS_ST_PASSIVE;
            MBS_TW: nxt_st_o = kind_ff;
            MBS_TG: nxt_st_oe = 3'h0;
            default: nxt_st_o = MBS_ST_PASSIVE;
        endcase
        if (nxt_bus == MBS_T1) begin
            nxt_st_o = nxt_kind;
        end
        if (!max_mode) begin
            nxt_st_oe = 3'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bus_ff <= MBS_TI;
            hs_ff <= MBS_HS_IDLE;
            kind_ff <= MBS_ST_PASSIVE;
            st_o_ff <= MBS_ST_PASSIVE;
            st_oe_ff <= 3'h0;
            gnt_pin_ff <= 1'b0;
            gnt_lo_ff <= 1'b0;
            sel_lo_ff <= 1'b0;
            early_ff <= 1'b0;
            block_ff <= 1'b0;
            lo_pend_ff <= 1'b0;
            cyc_done_ff <= 1'b0;
            granted_ff <= 1'b0;
        end else begin
            bus_ff <= nxt_bus;
            hs_ff <= nxt_hs;
            kind_ff <= nxt_kind;
            st_o_ff <= nxt_st_o;
            st_oe_ff <= nxt_st_oe;
            gnt_pin_ff <= nxt_gnt_pin;
            gnt_lo_ff <= nxt_gnt_lo;
            sel_lo_ff <= nxt_sel_lo;
            early_ff <= nxt_early;
            block_ff <= nxt_block;
            lo_pend_ff <= nxt_lo_pend;
            cyc_done_ff <= done_nxt;
            granted_ff <= gnt_nxt;
        end
    end

    assign link.cycle_status_o = st_o_ff;
    assign link.cycle_status_oe = st_oe_ff;
    assign link.hi_dev_o = 1'b0;
    assign link.hi_dev_oe = gnt_pin_ff;
    assign link.lo_dev_o = 1'b0;
    assign link.lo_dev_oe = gnt_lo_ff;
endmodule : mbs_device
`default_nettype wire

//--- hw/mbs_link_if.sv
// Link between the bus-status device end and the master end.
// Assumes a testbench resolves weak-one pull-ups from the enables.
`timescale 1ns/1ps
`default_nettype none
interface mbs_link_if;
    logic [2:0] cycle_status_o;
    logic [2:0] cycle_status_oe;
    logic [2:0] cycle_status_i;
    logic hi_dev_o;
    logic hi_dev_oe;
    logic lo_dev_o;
    logic lo_dev_oe;
    logic hi_mst_o;
    logic hi_mst_oe;
    logic lo_mst_o;
    logic lo_mst_oe;
    logic bus_handoff_pin_high_prio;
    logic bus_handoff_pin_low_prio;
    logic ready;
    modport device (
        output cycle_status_o, cycle_status_oe, hi_dev_o, hi_dev_oe,
        output lo_dev_o, lo_dev_oe,
        input bus_handoff_pin_high_prio, bus_handoff_pin_low_prio, ready
    );
    modport master (
        input cycle_status_i, bus_handoff_pin_high_prio,
        input bus_handoff_pin_low_prio,
        output hi_mst_o, hi_mst_oe, lo_mst_o, lo_mst_oe, ready
    );
endinterface : mbs_link_if
`default_nettype wire

//--- hw/mbs_master.sv
// Master end: requests the bus, waits for grant, releases.
// Assumes the handoff pin is asynchronous and pulled high when idle.
`timescale 1ns/1ps
`default_nettype none
module mbs_master
    import mbs_pkg::*;
#(
    parameter bit USE_LOW_PRIO = 1'b0
) (
    input wire logic clk_sys,
    input wire logic nrst,
    mbs_link_if.master link,
    input wire logic want_bus,
    input wire logic done_bus,
    output logic own_bus_ff,
    output logic [2:0] seen_status_ff
);
    typedef enum logic [2:0] {
        MBS_M_IDLE, MBS_M_REQ, MBS_M_WAIT, MBS_M_OWN, MBS_M_REL, MBS_M_GAP
    } mbs_mst_t;
    mbs_mst_t st_ff, nxt_st;
    logic [1:0] pin_sync_ff;
    logic [2:0] stat_s1_ff;
    logic prev_ff;
    logic [1:0] oe_dly_ff;
    logic pin_oe_ff, nxt_pin_oe;
    logic own_nxt;
    logic pin_in;

    assign pin_in = USE_LOW_PRIO ? link.bus_handoff_pin_low_prio
                                 : link.bus_handoff_pin_high_prio;

    always_comb begin
        nxt_st = st_ff;
        nxt_pin_oe = 1'b0;
        own_nxt = own_bus_ff;
        case (st_ff)
            MBS_M_IDLE: if (want_bus) begin
                nxt_st = MBS_M_REQ;
                nxt_pin_oe = 1'b1;
            end
            MBS_M_REQ: nxt_st = MBS_M_WAIT;
            MBS_M_WAIT: if (prev_ff && !pin_sync_ff[1]
                && !oe_dly_ff[1]) begin
                nxt_st = MBS_M_OWN;
                own_nxt = 1'b1;
            end
            MBS_M_OWN: if (done_bus) begin
                nxt_st = MBS_M_REL;
                nxt_pin_oe = 1'b1;
                own_nxt = 1'b0;
            end
            MBS_M_REL: nxt_st = MBS_M_GAP;
            MBS_M_GAP: nxt_st = MBS_M_IDLE;
            default: nxt_st = MBS_M_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_ff <= MBS_M_IDLE;
            pin_sync_ff <= 2'h3;
            prev_ff <= 1'b1;
            pin_oe_ff <= 1'b0;
            oe_dly_ff <= 2'h0;
            own_bus_ff <= 1'b0;
            stat_s1_ff <= MBS_ST_PASSIVE;
            seen_status_ff <= MBS_ST_PASSIVE;
        end else begin
            st_ff <= nxt_st;
            pin_sync_ff <= {pin_sync_ff[0], pin_in};
            prev_ff <= pin_sync_ff[1];
            pin_oe_ff <= nxt_pin_oe;
            oe_dly_ff <= {oe_dly_ff[0], pin_oe_ff};
            own_bus_ff <= own_nxt;
            stat_s1_ff <= link.cycle_status_i;
            seen_status_ff <= stat_s1_ff;
        end
    end

    assign link.hi_mst_o = 1'b0;
    assign link.hi_mst_oe = pin_oe_ff && !USE_LOW_PRIO;
    assign link.lo_mst_o = 1'b0;
    assign link.lo_mst_oe = pin_oe_ff && USE_LOW_PRIO;
    assign link.ready = 1'b1;
endmodule : mbs_master
`default_nettype wire

//--- hw/mbs_pkg.sv
// Package for the maximum-mode bus status and request/grant block.
// Assumes both ends run on one clock, clk_sys at 200 MHz.
package mbs_pkg;
    localparam logic [2:0] MBS_ST_INTERRUPT_ACK_CYCLE = 3'h0;
    localparam logic [2:0] MBS_ST_IORD = 3'h1;
    localparam logic [2:0] MBS_ST_IOWR = 3'h2;
    localparam logic [2:0] MBS_ST_HALT = 3'h3;
    localparam logic [2:0] MBS_ST_CODE = 3'h4;
    localparam logic [2:0] MBS_ST_MRD = 3'h5;
    localparam logic [2:0] MBS_ST_MWR = 3'h6;
    localparam logic [2:0] MBS_ST_PASSIVE = 3'h7;
    localparam logic MBS_STYLE_MAX = 1'b0;
    localparam int MBS_IDLE_START_CLKS = 3;
    typedef enum logic [2:0] {
        MBS_TI, MBS_T1, MBS_T2, MBS_T3, MBS_TW, MBS_T4, MBS_TG
    } mbs_bus_t;
    typedef enum logic [2:0] {
        MBS_HS_IDLE, MBS_HS_PEND, MBS_HS_GRANTED, MBS_HS_GAP
    } mbs_hs_t;
endpackage : mbs_pkg

//--- testbench/max_mode_bus_status_and_grant_test.sv
// Self-checking bench: device end and two master ends on one link.
// Assumes the bench resolves status lines and pins from the enables.
`timescale 1ns/1ps
`default_nettype none
module max_mode_bus_status_and_grant_test;
    import mbs_pkg::*;
    typedef struct packed {logic [2:0] kind; logic [2:0] exp;} mbs_row_t;
    logic clk_sys;
    logic nrst;
    logic cyc_req;
    logic [2:0] cyc_kind;
    logic [2:0] blk;
    logic [1:0] want;
    logic [1:0] done;
    logic [1:0] own;
    logic cyc_done_ff;
    logic granted_ff;
    logic [2:0] got;
    logic [2:0] got_seen;
    logic [2:0] seen;
    logic style_sel;
    int num_errors;
    int n_tests;
    int cycles;
    int low_clks;
    int base;
    mbs_row_t rows [7] = '{'{MBS_ST_INTERRUPT_ACK_CYCLE, 3'h0}, '{MBS_ST_IORD, 3'h1},
        '{MBS_ST_IOWR, 3'h2}, '{MBS_ST_HALT, 3'h3}, '{MBS_ST_CODE, 3'h4},
        '{MBS_ST_MRD, 3'h5}, '{MBS_ST_MWR, 3'h6}};
    mbs_link_if link ();
    mbs_link_if link2 ();
    // Weak-one status lines and pulled-up handoff pins
    assign link.cycle_status_i = link.cycle_status_o | ~link.cycle_status_oe;
    assign link.bus_handoff_pin_high_prio = ~(link.hi_dev_oe | link.hi_mst_oe);
    assign link.bus_handoff_pin_low_prio =
        ~(link.lo_dev_oe | link.lo_mst_oe | link2.lo_mst_oe);
    assign link2.cycle_status_i = link.cycle_status_i;
    assign link2.bus_handoff_pin_high_prio = link.bus_handoff_pin_high_prio;
    assign link2.bus_handoff_pin_low_prio = link.bus_handoff_pin_low_prio;
    mbs_device mbs_device_inst (.clk_sys(clk_sys), .nrst(nrst),
        .link(link.device), .bus_style_select(style_sel),
        .cyc_req(cyc_req), .cyc_kind(cyc_kind), .cyc_odd_low(blk[0]),
        .cyc_first_interrupt_ack_cycle(blk[1]), .lock_active(blk[2]),
        .cyc_done_ff(cyc_done_ff), .granted_ff(granted_ff));
    mbs_master #(.USE_LOW_PRIO(1'b0)) mbs_master_inst (.clk_sys(clk_sys),
        .nrst(nrst), .link(link.master), .want_bus(want[0]),
        .done_bus(done[0]), .own_bus_ff(own[0]), .seen_status_ff(seen));
    mbs_master #(.USE_LOW_PRIO(1'b1)) mbs_master_lo_inst (.clk_sys(clk_sys),
        .nrst(nrst), .link(link2.master), .want_bus(want[1]),
        .done_bus(done[1]), .own_bus_ff(own[1]), .seen_status_ff());
    mbs_link_asserts mbs_link_asserts_inst (.clk_sys(clk_sys), .nrst(nrst),
        .cycle_status_oe(link.cycle_status_oe),
        .cycle_status_i(link.cycle_status_i), .hi_dev_oe(link.hi_dev_oe),
        .lo_dev_oe(link.lo_dev_oe), .hi_mst_oe(link.hi_mst_oe));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (link.bus_handoff_pin_high_prio === 1'b0) begin
            low_clks <= low_clks + 1;
        end
        if (cycles == 3000) begin
            num_errors = num_errors + 1;
            finish_test();
        end
    end
    task automatic check(string what, logic [2:0] seen, logic [2:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_own(int m, logic v);
        for (int i = 0; i < 100 && own[m] !== v; i++) @(negedge clk_sys);
    endtask : wait_own
    task automatic run_cycle(logic [2:0] kind);
        cyc_kind = kind;
        cyc_req = 1'b1;
        got = 3'h7;
        for (int i = 0; i < 20 && got === 3'h7; i++) begin
            @(negedge clk_sys);
            got = link.cycle_status_i;
        end
        repeat (2) @(negedge clk_sys);
        got_seen = seen;
        cyc_req = 1'b0;
        for (int i = 0; i < 20 && cyc_done_ff !== 1'b1; i++) @(negedge clk_sys);
        check("cycle done", {2'h0, cyc_done_ff}, 3'h1);
        repeat (3) @(negedge clk_sys);
    endtask : run_cycle
    task automatic handover(int m);
        want[m] = 1'b1;
        wait_own(m, 1'b1);
        want[m] = 1'b0;
        check("status float", link.cycle_status_oe, 3'h0);
        check("granted", {2'h0, granted_ff}, 3'h1);
        done[m] = 1'b1;
        wait_own(m, 1'b0);
        done[m] = 1'b0;
        repeat (8) @(negedge clk_sys);
    endtask : handover
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        nrst = 1'b0;
        cyc_req = 1'b0;
        cyc_kind = 3'h0;
        style_sel = MBS_STYLE_MAX;
        blk = 3'h0;
        want = 2'h0;
        done = 2'h0;
        num_errors = 0;
        n_tests = 0;
        cycles = 0;
        low_clks = 0;
        repeat (10) @(negedge clk_sys);
        check("reset status", link.cycle_status_i, MBS_ST_PASSIVE);
        check("reset owner", {1'b0, own}, 3'h0);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        foreach (rows[i]) begin
            run_cycle(rows[i].kind);
            check("status code", got, rows[i].exp);
            check("seen status", got_seen, rows[i].exp);
        end
        $display("test status codes done");
        base = low_clks;
        handover(0);
        check("reclaimed", {2'h0, granted_ff}, 3'h0);
        check("pulse clocks", 3'(low_clks - base), 3'h3);
        $display("test idle handover done");
        want = 2'h3;
        wait_own(0, 1'b1);
        check("low waits", {2'h0, own[1]}, 3'h0);
        want[0] = 1'b0;
        done[0] = 1'b1;
        wait_own(0, 1'b0);
        done[0] = 1'b0;
        handover(1);
        $display("test priority done");
        for (int b = 0; b < 3; b++) begin
            blk = 3'h0;
            blk[b] = 1'b1;
            cyc_kind = MBS_ST_MRD;
            cyc_req = 1'b1;
            repeat (4) @(negedge clk_sys);
            want[0] = 1'b1;
            repeat (20) @(negedge clk_sys);
            check("blocked", {2'h0, own[0]}, 3'h0);
            blk = 3'h0;
            handover(0);
            cyc_req = 1'b0;
            repeat (8) @(negedge clk_sys);
        end
        $display("test release blockers done");
        style_sel = ~MBS_STYLE_MAX;
        repeat (3) @(negedge clk_sys);
        want[1] = 1'b1;
        repeat (20) @(negedge clk_sys);
        check("min float", link.cycle_status_oe, 3'h0);
        check("min no grant", {2'h0, own[1]}, 3'h0);
        nrst = 1'b0;
        want = 2'h0;
        style_sel = MBS_STYLE_MAX;
        repeat (3) @(negedge clk_sys);
        check("reset float", link.cycle_status_oe, 3'h0);
        nrst = 1'b1;
        repeat (4) @(negedge clk_sys);
        handover(0);
        check("after reset", {2'h0, granted_ff}, 3'h0);
        $display("test min mode and reset done");
        finish_test();
    end
endmodule : max_mode_bus_status_and_grant_test
`default_nettype wire

//--- testbench/mbs_link_asserts.sv
// Assertions on the link between the device end and the master ends.
// Assumes one clock domain and pins resolved by the testbench.
`timescale 1ns/1ps
`default_nettype none
module mbs_link_asserts (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [2:0] cycle_status_oe,
    input wire logic [2:0] cycle_status_i,
    input wire logic hi_dev_oe,
    input wire logic lo_dev_oe,
    input wire logic hi_mst_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_grant_one_clk: assert property (hi_dev_oe |=> !hi_dev_oe)
        else $error("high grant pulse too long");
    a_lo_grant_one: assert property (lo_dev_oe |=> !lo_dev_oe)
        else $error("low grant pulse too long");
    a_float_after_grant: assert property
        ((hi_dev_oe || lo_dev_oe) |=> cycle_status_oe == 3'h0)
        else $error("status driven after grant");
    a_status_whole: assert property
        (cycle_status_oe == 3'h0 || cycle_status_oe == 3'h7)
        else $error("status lines driven apart");
    a_single_grant: assert property (!(hi_dev_oe && lo_dev_oe))
        else $error("both pins granted");
    a_status_ends: assert property
        ((cycle_status_i != 3'h7) [*3] |=> cycle_status_i == 3'h7)
        else $error("status not back to passive");
    a_req_one_clk: assert property (hi_mst_oe |=> !hi_mst_oe)
        else $error("request pulse too long");
    a_gap_after: assert property ($fell(hi_mst_oe) |-> !hi_dev_oe)
        else $error("grant without idle clock");
    a_grant_in_time: assert property
        ($rose(hi_mst_oe) && cycle_status_oe != 3'h0 |-> ##[3:60] hi_dev_oe)
        else $error("request not granted in time");
    a_reclaim_bus: assert property
        ($rose(hi_mst_oe) && cycle_status_oe == 3'h0
            |-> ##[3:6] cycle_status_oe == 3'h7)
        else $error("bus not reclaimed after release");
endmodule : mbs_link_asserts
`default_nettype wire
